// >>> hdl/clock_sync_ref_config_regs.sv
// clocking and sync-reference configuration/status registers, AHB-Lite
// assumes one slave on the bus, single word transfers, and sample and
// edge-position data arriving from logic already on MCLK
//
// What this block does
// - sync-ref bit plus output timestamp enable put sync-ref on sample LSB
// - sync-ref bit selects sync-ref pins as timestamp source, not stamp pin
// - control one bit 2 puts device clock receiver into PECL mode
// - control one bit 1 puts sync-ref receiver into PECL mode
// - control one bit 0 inverts sync-ref before alignment use
// - control two bit 4 selects converter feedback gain, high at reset
// - control two bit 2 enables core supply noise suppression
// - control two bits 1:0 one-hot sampling clock delay, reset 0x1
// - 24-bit edge position of captured sync-ref edge at 0x2C
// - edge position is read-only; meaningful only after an edge evaluated
// - 16-bit input A full-scale code at 0x30, reset 0xA000
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module clock_sync_ref_config_regs
    import clk_sync_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SYNC_REF_IN,
    input wire logic TIMESTAMP_IN,
    input wire logic EDGE_POS_VALID,
    input wire logic [23:0] EDGE_POS,
    input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
    output logic [SAMPLE_W-1:0] SAMPLE_OUT,
    output logic ALIGN_SYNC,
    output logic DEVCLK_PECL_MODE,
    output logic SYNC_PECL_MODE,
    output logic FEEDBACK_GAIN_HIGH,
    output logic NOISE_SUPPRESS,
    output logic [1:0] SAMPLING_CLOCK_DELAY,
    output logic [15:0] FULL_SCALE_A
);

    bank_state_t q, d;
    logic [1:0] pin_level;
    logic sync_ref_s;
    logic stamp_s;
    logic take;
    logic addr_ok;
    logic stamp_bit;
    logic stamp_on;

    // both pin levels are asynchronous to MCLK
    pin_sync2 #(
        .W(2)
    ) u_pin_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .pin({SYNC_REF_IN, TIMESTAMP_IN}),
        .level(pin_level)
    );

    assign sync_ref_s = pin_level[1];
    assign stamp_s = pin_level[0];

    // hsize is not checked: only whole-word transfers are expected
    assign addr_ok = (HADDR[31:ADDR_TOP] == '0) && (HADDR[1:0] == 2'h0);
    assign take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

    // unmapped words read as zero and swallow writes
    function automatic logic [31:0] read_word(
        input bank_state_t s,
        input logic [7:0] idx
    );
        logic [31:0] w;
        w = 32'h00000000;
        case (idx)
            IDX_CTRL_ONE: w = {24'h000000, s.ctrl_one};
            IDX_CTRL_TWO: w = {24'h000000, s.ctrl_two};
            IDX_EDGE_POS: w = {8'h00, s.edge_pos};
            IDX_FS_A: w = {16'h0000, s.fs_a};
            IDX_TS_CTRL: w = {31'h00000000, s.ts_ctrl};
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction : read_word

    always_comb begin
        d = q;
        d.ready = 1'b1;
        if (q.wr_pend) begin
            case (q.wr_idx)
                IDX_CTRL_ONE: d.ctrl_one = HWDATA[7:0];
                IDX_CTRL_TWO: d.ctrl_two = HWDATA[7:0];
                IDX_FS_A: d.fs_a = HWDATA[15:0];
                IDX_TS_CTRL: d.ts_ctrl = HWDATA[TS_OUT_ENABLE];
                // edge position has no write path
                IDX_EDGE_POS: d.edge_pos = q.edge_pos;
                default: d.ctrl_one = q.ctrl_one;
            endcase
        end
        if (EDGE_POS_VALID) begin
            d.edge_pos = EDGE_POS;
        end
        d.wr_pend = take && HWRITE && addr_ok;
        d.wr_idx = HADDR[9:2];
        if (take && !HWRITE) begin
            // read from the next state so a write just ahead is seen
            if (addr_ok) begin
                d.rdata = read_word(d, HADDR[9:2]);
            end else begin
                d.rdata = 32'h00000000;
            end
        end
        d.align = sync_ref_s ^ q.ctrl_one[C1_SYNC_INVERT];
        d.sample = SAMPLE_IN;
        if (stamp_on) begin
            d.sample[0] = stamp_bit;
        end
    end

    // pick timestamp source: sync-ref pins or the dedicated stamp pin
    assign stamp_bit = q.ctrl_one[C1_SYNC_STAMP] ? sync_ref_s : stamp_s;
    assign stamp_on = q.ts_ctrl;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            q <= BANK_RST;
        end else begin
            q <= d;
        end
    end

    assign HRDATA = q.rdata;
    assign HREADYOUT = q.ready;
    // no error responses exist, so hresp is tied to OKAY by masking wr_pend with zero
    assign HRESP = q.wr_pend & 1'b0;
    assign SAMPLE_OUT = q.sample;
    assign ALIGN_SYNC = q.align;
    assign DEVCLK_PECL_MODE = q.ctrl_one[C1_DEVCLK_PECL];
    assign SYNC_PECL_MODE = q.ctrl_one[C1_SYNC_PECL];
    assign FEEDBACK_GAIN_HIGH = q.ctrl_two[C2_FB_GAIN];
    assign NOISE_SUPPRESS = q.ctrl_two[C2_NOISE_SUPP];
    assign SAMPLING_CLOCK_DELAY = q.ctrl_two[C2_DELAY_HI:C2_DELAY_LO];
    assign FULL_SCALE_A = q.fs_a;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    logic wr_one;
    logic wr_two;
    logic wr_fs;
    logic wr_edge;
    assign wr_one = q.wr_pend && (q.wr_idx == IDX_CTRL_ONE);
    assign wr_two = q.wr_pend && (q.wr_idx == IDX_CTRL_TWO);
    assign wr_fs = q.wr_pend && (q.wr_idx == IDX_FS_A);
    assign wr_edge = q.wr_pend && (q.wr_idx == IDX_EDGE_POS);

    property p_sync_on_lsb;
        q.ts_ctrl && q.ctrl_one[C1_SYNC_STAMP]
            |=> SAMPLE_OUT[0] == $past(sync_ref_s);
    endproperty
    a_sync_on_lsb: assert property (p_sync_on_lsb)
        else $error("sync-ref not carried on sample lsb");

    property p_stamp_pin_src;
        q.ts_ctrl && !q.ctrl_one[C1_SYNC_STAMP]
            |=> SAMPLE_OUT[0] == $past(stamp_s);
    endproperty
    a_stamp_pin_src: assert property (p_stamp_pin_src)
        else $error("timestamp source wrong");

    property p_lsb_untouched;
        // nrst term: at the release edge the flop still loads reset
        NRST && !q.ts_ctrl |=> SAMPLE_OUT == $past(SAMPLE_IN);
    endproperty
    a_lsb_untouched: assert property (p_lsb_untouched)
        else $error("sample altered while stamping off");

    property p_devclk_pecl;
        wr_one |=> DEVCLK_PECL_MODE == $past(HWDATA[C1_DEVCLK_PECL])
            && SYNC_PECL_MODE == $past(HWDATA[C1_SYNC_PECL]);
    endproperty
    a_devclk_pecl: assert property (p_devclk_pecl)
        else $error("pecl mode bits not taken from write");

    property p_polarity;
        q.ctrl_one[C1_SYNC_INVERT] ##1 q.ctrl_one[C1_SYNC_INVERT]
            |-> ALIGN_SYNC == !$past(sync_ref_s);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("sync-ref polarity not inverted");

    property p_ctrl_two;
        wr_two |=> FEEDBACK_GAIN_HIGH == $past(HWDATA[C2_FB_GAIN])
            && NOISE_SUPPRESS == $past(HWDATA[C2_NOISE_SUPP])
            && SAMPLING_CLOCK_DELAY == $past(HWDATA[1:0]);
    endproperty
    a_ctrl_two: assert property (p_ctrl_two)
        else $error("control two fields not taken from write");

    property p_ctrl_hold;
        !q.wr_pend |=> $stable(q.ctrl_two) && $stable(q.ctrl_one);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control register changed without a write");

    property p_edge_capture;
        EDGE_POS_VALID |=> q.edge_pos == $past(EDGE_POS);
    endproperty
    a_edge_capture: assert property (p_edge_capture)
        else $error("edge position not captured");

    property p_edge_ro;
        wr_edge && !EDGE_POS_VALID |=> $stable(q.edge_pos)
            && $stable(q.ctrl_one) && $stable(q.ctrl_two)
            && $stable(q.fs_a) && $stable(q.ts_ctrl);
    endproperty
    a_edge_ro: assert property (p_edge_ro)
        else $error("write to edge position had an effect");

    property p_fs_write;
        wr_fs |=> FULL_SCALE_A == $past(HWDATA[15:0]);
    endproperty
    a_fs_write: assert property (p_fs_write)
        else $error("full-scale code not taken from write");

    property p_read_edge;
        take && !HWRITE && addr_ok && (HADDR[9:2] == IDX_EDGE_POS)
            && !EDGE_POS_VALID
            |=> HRDATA == {8'h00, $past(q.edge_pos)};
    endproperty
    a_read_edge: assert property (p_read_edge)
        else $error("edge position readback wrong");

    property p_ready;
        1'b1 |-> HREADYOUT && !HRESP;
    endproperty
    a_ready: assert property (p_ready)
        else $error("slave not ready or not okay");

    // read checks skip a write to the same word one cycle ahead
    logic rd_now;
    logic wr_ts;
    assign rd_now = take && !HWRITE && addr_ok;
    assign wr_ts = q.wr_pend && (q.wr_idx == IDX_TS_CTRL);

    property p_read_one;
        rd_now && (HADDR[9:2] == IDX_CTRL_ONE) && !wr_one
            |=> HRDATA == {24'h000000, $past(q.ctrl_one)};
    endproperty
    a_read_one: assert property (p_read_one)
        else $error("control one readback wrong");

    property p_read_two;
        rd_now && (HADDR[9:2] == IDX_CTRL_TWO) && !wr_two
            |=> HRDATA == {24'h000000, $past(q.ctrl_two)};
    endproperty
    a_read_two: assert property (p_read_two)
        else $error("control two readback wrong");

    property p_read_fs;
        rd_now && (HADDR[9:2] == IDX_FS_A) && !wr_fs
            |=> HRDATA == {16'h0000, $past(q.fs_a)};
    endproperty
    a_read_fs: assert property (p_read_fs)
        else $error("full-scale readback wrong");

    property p_read_unmapped;
        take && !HWRITE && !addr_ok |=> HRDATA == 32'h00000000;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("bad address did not read zero");

    property p_rdata_hold;
        NRST && !(take && !HWRITE) |=> $stable(HRDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");

    property p_edge_hold;
        NRST && !EDGE_POS_VALID |=> $stable(q.edge_pos);
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("edge position changed without a capture");

    property p_fs_hold;
        NRST && !wr_fs |=> $stable(q.fs_a);
    endproperty
    a_fs_hold: assert property (p_fs_hold)
        else $error("full-scale code changed without a write");

    property p_stamp_write;
        wr_ts |=> q.ts_ctrl == $past(HWDATA[TS_OUT_ENABLE]);
    endproperty
    a_stamp_write: assert property (p_stamp_write)
        else $error("timestamp enable not taken from write");

    property p_stamp_hold;
        NRST && !wr_ts |=> $stable(q.ts_ctrl);
    endproperty
    a_stamp_hold: assert property (p_stamp_hold)
        else $error("timestamp enable changed without a write");

    property p_align_plain;
        NRST && !q.ctrl_one[C1_SYNC_INVERT]
            |=> ALIGN_SYNC == $past(sync_ref_s);
    endproperty
    a_align_plain: assert property (p_align_plain)
        else $error("sync-ref altered while not inverting");

    property p_sync_pecl;
        wr_one |=> SYNC_PECL_MODE == $past(HWDATA[C1_SYNC_PECL]);
    endproperty
    a_sync_pecl: assert property (p_sync_pecl)
        else $error("sync-ref pecl bit not taken from write");

    property p_noise;
        wr_two |=> NOISE_SUPPRESS == $past(HWDATA[C2_NOISE_SUPP]);
    endproperty
    a_noise: assert property (p_noise)
        else $error("noise suppress bit not taken from write");

    property p_delay;
        wr_two |=> SAMPLING_CLOCK_DELAY
            == $past(HWDATA[C2_DELAY_HI:C2_DELAY_LO]);
    endproperty
    a_delay: assert property (p_delay)
        else $error("sampling delay not taken from write");

    c_write_one: cover property (wr_one);
    c_sync_stamp: cover property (q.ts_ctrl && q.ctrl_one[C1_SYNC_STAMP]);
    c_edge_seen: cover property (EDGE_POS_VALID ##1 take && !HWRITE);
    c_fs_min: cover property (wr_fs && HWDATA[15:0] == FS_A_MIN_GOOD);

endmodule : clock_sync_ref_config_regs

// >>> hdl/clk_sync_pkg.sv
// constants and types for the clock and sync-reference register bank
// assumes a 32-bit AHB-Lite register bus, one aligned word per register
package clk_sync_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_ONE = 8'h2A;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h2B;
    localparam logic [7:0] IDX_EDGE_POS = 8'h2C;
    localparam logic [7:0] IDX_FS_A = 8'h30;
    localparam logic [7:0] IDX_TS_CTRL = 8'h34;

    // decode window: haddr bits from this one up must be zero
    localparam int ADDR_TOP = 10;

    // clock_control_one fields
    localparam int C1_SYNC_STAMP = 3;
    localparam int C1_DEVCLK_PECL = 2;
    localparam int C1_SYNC_PECL = 1;
    localparam int C1_SYNC_INVERT = 0;

    // clock_control_two fields
    localparam int C2_FB_GAIN = 4;
    localparam int C2_NOISE_SUPP = 2;
    localparam int C2_DELAY_HI = 1;
    localparam int C2_DELAY_LO = 0;

    // own timestamp control register field
    localparam int TS_OUT_ENABLE = 0;

    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h11;
    localparam logic [23:0] EDGE_POS_RST = 24'h000000;
    localparam logic [15:0] FS_A_RST = 16'hA000;
    localparam logic [15:0] FS_A_MIN_GOOD = 16'h2000;
    localparam logic [15:0] FS_A_MAX = 16'hFFFF;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int SAMPLE_W = 8;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [23:0] edge_pos;
        logic [15:0] fs_a;
        logic ts_ctrl;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
        logic [SAMPLE_W-1:0] sample;
        logic align;
    } bank_state_t;

    localparam bank_state_t BANK_RST = '{
        ctrl_one: CTRL_ONE_RST,
        ctrl_two: CTRL_TWO_RST,
        edge_pos: EDGE_POS_RST,
        fs_a: FS_A_RST,
        ts_ctrl: 1'b0,
        wr_pend: 1'b0,
        wr_idx: 8'h00,
        rdata: 32'h00000000,
        ready: 1'b1,
        sample: '0,
        align: 1'b0
    };

endpackage : clk_sync_pkg

// >>> hdl/pin_sync2.sv
// two-flop synchroniser for pin levels entering the MCLK domain
// assumes inputs are asynchronous levels; first stage feeds only second
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } sync_state_t;

    sync_state_t q, d;

    always_comb begin
        d = q;
        d.meta = pin;
        d.safe = q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.safe;

endmodule : pin_sync2

// >>> sim/testbench.sv
// self-checking bench for the clock and sync-reference register bank
// assumes zero-wait AHB-Lite slave and 3-edge pin-to-output latency
`timescale 1ns/1ps
module testbench;
    import clk_sync_pkg::*;

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end

    typedef struct {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } row_t;

    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = '0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = '0;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic SYNC_REF_IN = 1'b0;
    logic TIMESTAMP_IN = 1'b0;
    logic EDGE_POS_VALID = 1'b0;
    logic [23:0] EDGE_POS = '0;
    logic [SAMPLE_W-1:0] SAMPLE_IN = '0;
    logic [SAMPLE_W-1:0] SAMPLE_OUT;
    logic ALIGN_SYNC, DEVCLK_PECL_MODE, SYNC_PECL_MODE;
    logic FEEDBACK_GAIN_HIGH, NOISE_SUPPRESS;
    logic [1:0] SAMPLING_CLOCK_DELAY;
    logic [15:0] FULL_SCALE_A;
    logic [31:0] rd;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    row_t rows[9] = '{
        '{32'h000000A8, 32'h000001FF, 32'h000000FF},
        '{32'h000000A9, 32'h0000005A, 32'h00000000},
        '{32'h000000A8, 32'h00000000, 32'h00000000},
        '{32'h000000AC, 32'h000000EE, 32'h000000EE},
        '{32'h000000AC, 32'h00000011, 32'h00000011},
        '{32'h000000C0, 32'h00002000, 32'h00002000},
        '{32'h000000C0, 32'h12345678, 32'h00005678},
        '{32'h000000C0, 32'h0000FFFF, 32'h0000FFFF},
        '{32'h00000100, 32'h0000005A, 32'h00000000}};

    clock_sync_ref_config_regs dut (.MCLK(MCLK), .NRST(NRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SYNC_REF_IN(SYNC_REF_IN),
        .TIMESTAMP_IN(TIMESTAMP_IN), .EDGE_POS_VALID(EDGE_POS_VALID),
        .EDGE_POS(EDGE_POS), .SAMPLE_IN(SAMPLE_IN), .SAMPLE_OUT(SAMPLE_OUT),
        .ALIGN_SYNC(ALIGN_SYNC), .DEVCLK_PECL_MODE(DEVCLK_PECL_MODE),
        .SYNC_PECL_MODE(SYNC_PECL_MODE),
        .FEEDBACK_GAIN_HIGH(FEEDBACK_GAIN_HIGH),
        .NOISE_SUPPRESS(NOISE_SUPPRESS),
        .SAMPLING_CLOCK_DELAY(SAMPLING_CLOCK_DELAY),
        .FULL_SCALE_A(FULL_SCALE_A));

    always #2.5 MCLK = ~MCLK;

    // run needs about 130 cycles; reaching the 5000-cycle limit is a hang
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // one single transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, d);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HADDR <= a;
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= wr;
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) @(posedge MCLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) @(posedge MCLK);
        rd = HRDATA;
    endtask : bus

    // pin levels need three edges to reach the outputs
    task automatic settle();
        repeat (4) @(posedge MCLK);
        #1;
    endtask : settle

    initial begin
        repeat (5) @(posedge MCLK);
        NRST <= 1'b1;
        bus(1'b0, 32'hA8, 0);
        `CHK("ctrl_one rst", 32'h00, rd)
        bus(1'b0, 32'hAC, 0);
        `CHK("ctrl_two rst", 32'h11, rd)
        bus(1'b0, 32'hC0, 0);
        `CHK("fs_a rst", 32'hA000, rd)
        `CHK("gain rst", 1'b1, FEEDBACK_GAIN_HIGH)
        `CHK("delay rst", 2'h1, SAMPLING_CLOCK_DELAY)
        $display("test reset_values done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].addr, rows[i].wdata);
            bus(1'b0, rows[i].addr, 0);
            `CHK("readback", rows[i].rexp, rd)
        end
        $display("test readback_rows done");
        bus(1'b1, 32'hA8, 32'h06);
        bus(1'b1, 32'hAC, 32'h06);
        #1;
        `CHK("devclk pecl", 1'b1, DEVCLK_PECL_MODE)
        `CHK("sync pecl", 1'b1, SYNC_PECL_MODE)
        `CHK("noise", 1'b1, NOISE_SUPPRESS)
        `CHK("gain low", 1'b0, FEEDBACK_GAIN_HIGH)
        `CHK("delay", 2'h2, SAMPLING_CLOCK_DELAY)
        `CHK("fs out", 16'hFFFF, FULL_SCALE_A)
        $display("test control_outputs done");
        @(posedge MCLK);
        EDGE_POS_VALID <= 1'b1;
        EDGE_POS <= 24'hABCDEF;
        @(posedge MCLK);
        EDGE_POS_VALID <= 1'b0;
        bus(1'b1, 32'hB0, 32'h00000000);
        `CHK("hresp okay", 1'b0, HRESP)
        bus(1'b0, 32'hB0, 0);
        // software picks the separate sync delay select from this value;
        // that select lives outside this bank and stays zero here
        `CHK("edge pos", 32'h00ABCDEF, rd)
        bus(1'b0, 32'hA8, 0);
        `CHK("ctrl_one kept", 32'h06, rd)
        $display("test edge_position done");
        SYNC_REF_IN <= 1'b1;
        settle();
        `CHK("align", 1'b1, ALIGN_SYNC)
        bus(1'b1, 32'hA8, 32'h01);
        settle();
        `CHK("align inv", 1'b0, ALIGN_SYNC)
        @(posedge MCLK);
        SAMPLE_IN <= 8'h55;
        settle();
        `CHK("sample plain", 8'h55, SAMPLE_OUT)
        bus(1'b1, 32'hD0, 32'h01);
        settle();
        `CHK("stamp pin", 8'h54, SAMPLE_OUT)
        @(posedge MCLK);
        TIMESTAMP_IN <= 1'b1;
        SAMPLE_IN <= 8'hAA;
        settle();
        `CHK("stamp pin high", 8'hAB, SAMPLE_OUT)
        // stamp pin low again so only the sync-ref can set the lsb
        bus(1'b1, 32'hA8, 32'h08);
        TIMESTAMP_IN <= 1'b0;
        settle();
        `CHK("stamp sync", 8'hAB, SAMPLE_OUT)
        bus(1'b1, 32'hD0, 32'h00);
        settle();
        `CHK("stamp off", 8'hAA, SAMPLE_OUT)
        $display("test sample_stamp done");
        @(posedge MCLK);
        NRST <= 1'b0;
        #1;
        `CHK("fs mid rst", 16'hA000, FULL_SCALE_A)
        `CHK("delay mid rst", 2'h1, SAMPLING_CLOCK_DELAY)
        @(posedge MCLK);
        NRST <= 1'b1;
        bus(1'b0, 32'hA8, 0);
        `CHK("ctrl_one mid rst", 32'h00, rd)
        $display("test mid_reset done");
        stop_test();
    end

endmodule : testbench
